// >>> hdl/occs_cfg.svh
// Constants for the output clock source block: offsets, fields, resets.
// Assumes a 32-bit register bus with one aligned word per register.
`ifndef OCCS_CFG_SVH
`define OCCS_CFG_SVH

`define OCCS_ADDR_W        8
`define OCCS_OFF_BCR       8'h00
`define OCCS_OFF_RATE      8'h08
`define OCCS_OFF_ASSY      8'h10
`define OCCS_OFF_ARC       8'h1c
`define OCCS_OFF_STATUS    8'h20

`define OCCS_BCR_EXT_BIT   4
`define OCCS_BCR_EN_BIT    5
`define OCCS_BCR_WMASK     32'h0000_0030
`define OCCS_BCR_RESET     32'h0000_0000

`define OCCS_RATE_W        18
`define OCCS_RATE_RESET    18'h00096

`define OCCS_ARC_CODE_W    9
`define OCCS_ARC_ALT_BIT   9
`define OCCS_ARC_RESET     10'h000

`define OCCS_ASSY_CHAN_LSB 16
`define OCCS_ASSY_DIFF_BIT 20
`define OCCS_ASSY_CUST_BIT 21
`define OCCS_ASSY_PID_BIT  22
`define OCCS_ASSY_HL_BIT   23

`define OCCS_RESP_OKAY     2'b00
`define OCCS_RESP_SLVERR   2'b10

`endif

// >>> hdl/occs_pkg.sv
// Types for the output clock source block.
// Assumes occs_cfg.svh carries the numeric constants.
package occs_pkg;

  // Clock source mode, coded as {external clock, alternate reference}
  typedef enum logic [1:0] {
    OCCS_SRC_MASTER = 2'b00,
    OCCS_SRC_ADJREF = 2'b01,
    OCCS_SRC_DACCLK = 2'b10,
    OCCS_SRC_EXTREF = 2'b11
  } occs_src_e;

  typedef logic [1:0] occs_chan_code_t;

endpackage : occs_pkg

// >>> hdl/occs_clock_source.sv
// Output clock source selection, adjustable reference and assembly options.
// Assumes an AXI4-Lite master on aclk and a clock I/O pin whose incoming
// side arrives as link_clk, unrelated in phase to aclk.
`include "occs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module occs_clock_source #(
  parameter logic [11:0] FW_REV       = 12'h001, // Arbitrary value
  parameter logic [1:0]  CHAN_CODE    = 2'h3,
  parameter logic [1:0]  FILTER_CODE  = 2'h0,
  parameter logic        DIFF_OUT     = 1'b1,
  parameter logic        CUSTOM_CLK   = 1'b0,
  parameter logic        PRODUCT_ID   = 1'b0,    // Arbitrary value
  parameter logic        HIGH_LEVEL   = 1'b0
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`OCCS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`OCCS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    link_clk,
  output logic                         clk_io_o,
  output logic                         clk_io_oe,
  output logic                         dac_update,
  output logic                         adj_ref_clk
);

  // Link-domain reset, synchronised into link_clk
  logic [1:0] link_rst_q;
  logic       link_rst_n;
  logic       link_tog_q;

  always_ff @(posedge link_clk) begin
    link_rst_q <= {link_rst_q[0], aresetn};
  end
  assign link_rst_n = link_rst_q[1];

  // One toggle per incoming edge; a toggle survives the crossing as an event
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      link_tog_q <= 1'b0;
    end else begin
      link_tog_q <= ~link_tog_q;
    end
  end

  // Toggle crossing into aclk; the second and third stages feed the edge detect.
  // Limitation: incoming edges faster than aclk are merged, not counted.
  logic [2:0] tog_sync_q;
  logic       ext_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_sync_q <= 3'h0;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], link_tog_q};
    end
  end
  assign ext_edge = tog_sync_q[2] ^ tog_sync_q[1];

  // AXI write channel holding registers
  logic                    aw_hold_q;
  logic [`OCCS_ADDR_W-1:0] awaddr_q;
  logic                    w_hold_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    do_write;

  // Each channel is taken once and held until the response is accepted
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  // Write decode; the assembly word is accepted but changes nothing
  logic        wr_bcr;
  logic        wr_rate;
  logic        wr_arc;
  logic        wr_known;
  logic [31:0] wmask;

  assign wr_bcr   = do_write && (awaddr_q == `OCCS_OFF_BCR);
  assign wr_rate  = do_write && (awaddr_q == `OCCS_OFF_RATE);
  assign wr_arc   = do_write && (awaddr_q == `OCCS_OFF_ARC);
  assign wr_known = (awaddr_q == `OCCS_OFF_BCR) || (awaddr_q == `OCCS_OFF_RATE) ||
                    (awaddr_q == `OCCS_OFF_ARC) || (awaddr_q == `OCCS_OFF_ASSY) ||
                    (awaddr_q == `OCCS_OFF_STATUS);

  // Byte-lane mask from the strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `OCCS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? `OCCS_RESP_OKAY : `OCCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Software registers
  logic [31:0]              bcr_q;
  logic [31:0]              bcr_d;
  logic [`OCCS_RATE_W-1:0]  rate_q;
  logic [31:0]              rate_d;
  logic [9:0]               arc_q;
  logic [31:0]              arc_d;

  assign bcr_d  = ((bcr_q & ~wmask) | (wdata_q & wmask)) & `OCCS_BCR_WMASK;
  assign rate_d = ({14'h0, rate_q} & ~wmask) | (wdata_q & wmask);
  assign arc_d  = ({22'h0, arc_q} & ~wmask) | (wdata_q & wmask);

  // Board control: only external clock and clock enable are kept here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcr_q <= `OCCS_BCR_RESET;
    end else if (wr_bcr) begin
      bcr_q <= bcr_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_q <= `OCCS_RATE_RESET;
    end else if (wr_rate) begin
      rate_q <= rate_d[`OCCS_RATE_W-1:0];
    end
  end

  // Adjustable reference control: code and alternate select, zero at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arc_q <= `OCCS_ARC_RESET;
    end else if (wr_arc) begin
      arc_q <= arc_d[9:0];
    end
  end

  // Mode decode
  logic                   ext_clock;
  logic                   clk_enable;
  logic                   alt_ref;
  logic [`OCCS_ARC_CODE_W-1:0] adj_code;
  occs_pkg::occs_src_e    src_mode;

  assign ext_clock  = bcr_q[`OCCS_BCR_EXT_BIT];
  assign clk_enable = bcr_q[`OCCS_BCR_EN_BIT];
  assign alt_ref    = arc_q[`OCCS_ARC_ALT_BIT];
  assign adj_code   = arc_q[`OCCS_ARC_CODE_W-1:0];
  assign src_mode   = occs_pkg::occs_src_e'({ext_clock, alt_ref});

  // Adjustable reference: toggles every code+1 cycles
  logic [`OCCS_ARC_CODE_W-1:0] adj_cnt_q;
  logic                        adj_tick;
  logic                        adj_ref_q;

  assign adj_tick = (adj_cnt_q >= adj_code);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adj_cnt_q <= '0;
      adj_ref_q <= 1'b0;
    end else if (adj_tick) begin
      adj_cnt_q <= '0;
      adj_ref_q <= ~adj_ref_q;
    end else begin
      adj_cnt_q <= adj_cnt_q + 1'b1;
    end
  end

  // Source selection for the rate generator and the pin
  logic gen_src_tick;
  logic direct_tick;
  logic pin_drive;
  logic pin_level;
  logic mclk_div_q;

  always_comb begin
    gen_src_tick = 1'b0;
    direct_tick  = 1'b0;
    pin_drive    = 1'b0;
    pin_level    = 1'b0;
    case (src_mode)
      occs_pkg::OCCS_SRC_MASTER: begin
        gen_src_tick = 1'b1;
        pin_drive    = 1'b1;
        pin_level    = mclk_div_q;
      end
      occs_pkg::OCCS_SRC_ADJREF: begin
        gen_src_tick = adj_tick;
        pin_drive    = 1'b1;
        pin_level    = adj_ref_q;
      end
      occs_pkg::OCCS_SRC_DACCLK: begin
        direct_tick  = ext_edge;
      end
      occs_pkg::OCCS_SRC_EXTREF: begin
        gen_src_tick = ext_edge;
      end
      default: begin
        gen_src_tick = 1'b0;
      end
    endcase
  end

  // Master clock image on the pin: the fastest square wave aclk can form
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mclk_div_q <= 1'b0;
    end else begin
      mclk_div_q <= ~mclk_div_q;
    end
  end

  // Pin drive registered so the enable and level change together
  logic clk_io_o_q;
  logic clk_io_oe_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_io_o_q  <= 1'b0;
      clk_io_oe_q <= 1'b0;
    end else begin
      clk_io_o_q  <= pin_drive & pin_level;
      clk_io_oe_q <= pin_drive;
    end
  end
  assign clk_io_o    = clk_io_o_q;
  assign clk_io_oe   = clk_io_oe_q;
  assign adj_ref_clk = adj_ref_q;

  // Rate generator: one update per rate source ticks; rate 0 acts as 1
  logic [`OCCS_RATE_W-1:0] gen_cnt_q;
  logic                    gen_done;
  logic                    update_d;
  logic                    update_q;

  assign gen_done = gen_src_tick && ((gen_cnt_q + 1'b1) >= rate_q);
  assign update_d = clk_enable && (direct_tick || gen_done);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_cnt_q <= '0;
    end else if (!clk_enable || gen_done) begin
      gen_cnt_q <= '0;
    end else if (gen_src_tick) begin
      gen_cnt_q <= gen_cnt_q + 1'b1;
    end
  end

  // Update strobe and a running count that software can watch
  logic [15:0] upd_cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      update_q  <= 1'b0;
      upd_cnt_q <= 16'h0000;
    end else begin
      update_q  <= update_d;
      upd_cnt_q <= upd_cnt_q + {15'h0000, update_d};
    end
  end
  assign dac_update = update_q;

  // Assembly options: fixed build strap values, top byte zero
  logic [31:0] assy_word;

  assign assy_word = {8'h00,
                      HIGH_LEVEL,
                      PRODUCT_ID,
                      CUSTOM_CLK,
                      DIFF_OUT,
                      FILTER_CODE,
                      occs_pkg::occs_chan_code_t'(CHAN_CODE),
                      4'h0,
                      FW_REV};

  // Status word: live source mode, pin direction, enable and update count
  logic [31:0] status_word;

  assign status_word = {12'h000, src_mode, clk_io_oe_q, clk_enable, upd_cnt_q};

  // Read decode and data selection
  logic        rd_bcr;
  logic        rd_rate;
  logic        rd_assy;
  logic        rd_arc;
  logic        rd_stat;
  logic        rd_known;
  logic [31:0] rd_word;

  assign rd_bcr   = (s_axi_araddr == `OCCS_OFF_BCR);
  assign rd_rate  = (s_axi_araddr == `OCCS_OFF_RATE);
  assign rd_assy  = (s_axi_araddr == `OCCS_OFF_ASSY);
  assign rd_arc   = (s_axi_araddr == `OCCS_OFF_ARC);
  assign rd_stat  = (s_axi_araddr == `OCCS_OFF_STATUS);
  assign rd_known = rd_bcr | rd_rate | rd_assy | rd_arc | rd_stat;
  assign rd_word  = ({32{rd_bcr}}  & bcr_q)
                  | ({32{rd_rate}} & {14'h0000, rate_q})
                  | ({32{rd_assy}} & assy_word)
                  | ({32{rd_arc}}  & {22'h000000, arc_q})
                  | ({32{rd_stat}} & status_word);

  // Read channel: one read outstanding, data from flip-flops
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `OCCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_known ? `OCCS_RESP_OKAY : `OCCS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : occs_clock_source

`default_nettype wire

// >>> dv/occs_clock_source_properties.sv
// Port-level checks for the output clock source block.
// Assumes it is bound into every occs_clock_source instance.
`include "occs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module occs_clock_source_properties #(
  parameter logic [1:0] CHAN_CODE   = 2'h3,
  parameter logic [1:0] FILTER_CODE = 2'h0,
  parameter logic       DIFF_OUT    = 1'b1,
  parameter logic       CUSTOM_CLK  = 1'b0,
  parameter logic       PRODUCT_ID  = 1'b0,
  parameter logic       HIGH_LEVEL  = 1'b0
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        clk_io_o,
  input wire logic        clk_io_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshakes seen at this edge; the bench offers both write halves at once
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic w_take  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic known   = s_axi_araddr inside {8'h00, 8'h08, 8'h10, 8'h1c, 8'h20};
  wire logic assy_rd = ar_take && s_axi_araddr == `OCCS_OFF_ASSY;
  property p_write_answer;
    w_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_b_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken while answering");
  property p_read_answer;
    ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_unmapped;
    ar_take && !known |=> s_axi_rresp == `OCCS_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_assy_fields;
    assy_rd |=> s_axi_rdata[23:16] ==
      {HIGH_LEVEL, PRODUCT_ID, CUSTOM_CLK, DIFF_OUT, FILTER_CODE, CHAN_CODE};
  endproperty
  a_assy_fields: assert property (p_assy_fields) else $error("assembly fields wrong");
  property p_assy_top;
    assy_rd |=> s_axi_rdata[31:24] == 8'h00 && s_axi_rresp == `OCCS_RESP_OKAY;
  endproperty
  a_assy_top: assert property (p_assy_top) else $error("assembly top byte set");
  property p_arc_top;
    ar_take && s_axi_araddr == `OCCS_OFF_ARC |=> s_axi_rdata[31:10] == 22'h0;
  endproperty
  a_arc_top: assert property (p_arc_top) else $error("reference upper bits set");
  property p_release_drive;
    $rose(aresetn) |-> ##[1:2] clk_io_oe;
  endproperty
  a_release_drive: assert property (p_release_drive) else $error("pin not driven");
  // Reset itself must be watched, so this one is never disabled
  property p_reset;
    disable iff (1'b0) !aresetn |=> !clk_io_oe && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_pin_quiet;
    !clk_io_oe |-> !clk_io_o;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("pin level while input");
  c_input: cover property ($fell(clk_io_oe));
  c_unmapped: cover property (ar_take && !known);
  c_write: cover property (w_take);
endmodule : occs_clock_source_properties
bind occs_clock_source occs_clock_source_properties #(.CHAN_CODE(CHAN_CODE),
  .FILTER_CODE(FILTER_CODE), .DIFF_OUT(DIFF_OUT), .CUSTOM_CLK(CUSTOM_CLK),
  .PRODUCT_ID(PRODUCT_ID), .HIGH_LEVEL(HIGH_LEVEL)) u_props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata,
  .s_axi_rresp, .clk_io_o, .clk_io_oe);
`default_nettype wire

// >>> dv/occs_link_partner.sv
// Model of another board feeding the shared clock pin.
// Assumes the bench enables it only while the block treats the pin as input.
`timescale 1ns/100ps
`default_nettype none
module occs_link_partner (
  input  wire logic run,
  input  wire logic slow,
  output logic      clk_out
);
  // Clock runs only inside frames and rests low between them
  initial begin
    clk_out = 1'b0;
    #3;
    forever begin
      #(slow ? 12 : 6);
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule : occs_link_partner
`default_nettype wire

// >>> dv/occs_clock_source_tb.sv
// Self-checking bench for the output clock source block.
// Assumes the block, its checker and the partner model are compiled first.
`include "occs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module occs_clock_source_tb;
  localparam logic [1:0]  CHN = 2'h1;
  localparam logic [11:0] FW  = 12'h5a3; // Arbitrary value
  logic        aclk = 1'b0, aresetn = 1'b0, run = 1'b1, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        clk_io_o, clk_io_oe, dac_update, adj_ref_clk, peer_clk;
  logic [31:0] bcr_m = 32'h0, arc_m = 32'h0, rate_m = 32'h96;
  logic [7:0]  adr [6] = '{8'h00, 8'h08, 8'h10, 8'h1c, 8'h04, 8'h3c};
  int          miscompares = 0, tests_run = 0;
  // Pin level resolved from whichever side drives it
  wire logic link_clk = clk_io_oe ? clk_io_o : peer_clk;
  occs_clock_source #(.FW_REV(FW), .CHAN_CODE(CHN), .DIFF_OUT(1'b0), .CUSTOM_CLK(1'b1),
    .HIGH_LEVEL(1'b1)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_clk, .clk_io_o, .clk_io_oe, .dac_update,
    .adj_ref_clk);
  occs_link_partner peer (.run, .slow, .clk_out(peer_clk));
  always #50 aclk = ~aclk;
  // Expected {response, data} of an access, from the register model
  function automatic logic [33:0] model(input logic [7:0] a);
    case (a)
      `OCCS_OFF_BCR:  return {`OCCS_RESP_OKAY, bcr_m};
      `OCCS_OFF_RATE: return {`OCCS_RESP_OKAY, rate_m};
      `OCCS_OFF_ASSY: return {10'h0, 4'b1010, 2'h0, CHN, 4'h0, FW};
      `OCCS_OFF_ARC:  return {`OCCS_RESP_OKAY, arc_m};
      default:        return {`OCCS_RESP_SLVERR, 32'h0};
    endcase
  endfunction : model
  task automatic results();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic hang();
    miscompares++;
    results();
  endtask : hang
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    logic [1:0] r;
    logic [31:0] k;
    int n;
    tb = 1'b0;
    // Byte lanes that the strobes let through
    k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; !tb && n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) hang();
    cmp({r, 32'h0}, model(a) & {2'h3, 32'h0});
    // Only writable bits in strobed lanes land; fixed registers ignore writes
    case (a)
      `OCCS_OFF_BCR:  bcr_m = ((bcr_m & ~k) | (d & k)) & `OCCS_BCR_WMASK;
      `OCCS_OFF_RATE: rate_m = ((rate_m & ~k) | (d & k)) & 32'h3ffff;
      `OCCS_OFF_ARC:  arc_m = ((arc_m & ~k) | (d & k)) & 32'h3ff;
      default:        ;
    endcase
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    logic [33:0] got;
    int n;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; !tr && n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) hang();
    cmp(got, model(a));
  endtask : rd
  // Cycles between two level changes of the pin or of the reference
  task automatic period(input bit pin, output int n);
    logic v;
    int i;
    @(negedge aclk);
    v = pin ? clk_io_o : adj_ref_clk;
    for (i = 0; i < 200 && (pin ? clk_io_o : adj_ref_clk) === v; i++) @(negedge aclk);
    v = pin ? clk_io_o : adj_ref_clk;
    for (n = 0; n < 200 && (pin ? clk_io_o : adj_ref_clk) === v; n++) @(negedge aclk);
    if (i == 200 || n == 200) hang();
    @(posedge aclk);
  endtask : period
  task automatic pulses(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(negedge aclk);
      c += int'(dac_update === 1'b1);
    end
    @(posedge aclk);
  endtask : pulses
  initial begin
    int n, m, code;
    void'($urandom(32'h3345f633));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b0;
    foreach (adr[i]) rd(adr[i]);
    repeat (24) begin
      n = $urandom_range(0, 5);
      wr(adr[n], $urandom, 4'($urandom));
      rd(adr[n]);
    end
    wr(`OCCS_OFF_RATE, 32'h2, 4'hf);
    // Every source mode: pin direction; pin clock and update pacing when driving, updates only while the partner runs otherwise
    for (m = 0; m < 4; m++) begin
      code = $urandom_range(0, 12);
      wr(`OCCS_OFF_ARC, {22'h0, m[0], code[8:0]}, 4'hf);
      wr(`OCCS_OFF_BCR, {26'h0, 1'b1, m[1], 4'h0}, 4'hf);
      repeat (4) @(posedge aclk);
      // Look between edges so the pin enable has settled
      @(negedge aclk);
      cmp(clk_io_oe, !m[1]);
      if (!m[1]) begin
        period(1'b1, n);
        cmp(n, m[0] ? code + 1 : 1);
        period(1'b0, n);
        cmp(n, code + 1);
        // A window of whole update periods holds an exact number of updates
        pulses(m[0] ? 8 * (code + 1) : 40, n);
        cmp(n, m[0] ? 4 : 20);
      end else begin
        run <= 1'b1;
        slow <= m[0];
        pulses(300, n);
        cmp(n > 0, 1);
        run <= 1'b0;
        repeat (10) @(posedge aclk);
        pulses(50, n);
        cmp(n, 0);
      end
    end
    results();
  end
endmodule : occs_clock_source_tb
`default_nettype wire
